// [hdl/dso_pkg.sv]
// drive status output package: selector codes, timer figures, widths
// assumes a 50 MHz control clock feeding every block of the status logic
package dso_pkg;
  // control clock rate and millisecond tick
  localparam int unsigned CLK_HZ        = 50000000;      // sys_clk rate
  localparam int unsigned TICK_CYCLES   = CLK_HZ / 1000; // cycles per ms
  // qualification times in milliseconds
  localparam int unsigned LIMIT_MIN_MS  = 100;           // limiting min width
  localparam int unsigned LIMIT_DLY_MS  = 20;            // limiting delay
  localparam int unsigned SPEED_HOLD_MS = 100;           // speed-off hold
  // heat-sink margins in degrees C
  localparam int unsigned HS_ON_MARGIN  = 5;             // warn margin
  localparam int unsigned HS_OFF_MARGIN = 8;             // release margin
  // current input break threshold in microamps
  localparam int unsigned WIRE_BREAK_UA = 2000;          // 2 mA
  // assignment code layout
  localparam logic [10:0] NEG_OFFSET    = 11'h3e8;       // 1000 = inverted
  localparam logic [10:0] CODE_RESET    = 11'h000;       // code after reset
  // selector codes of status flags
  localparam logic [6:0] SEL_TORQUE     = 7'h04; // 4
  localparam logic [6:0] SEL_LIM        = 7'h05; // 5
  localparam logic [6:0] SEL_KEYPAD     = 7'h08; // 8
  localparam logic [6:0] SEL_READY      = 7'h0a; // 10
  localparam logic [6:0] SEL_CONTACTOR  = 7'h0f; // 15
  localparam logic [6:0] SEL_LIMDLY     = 7'h16; // 22
  localparam logic [6:0] SEL_COMM       = 7'h1b; // 27
  localparam logic [6:0] SEL_HEAT       = 7'h1c; // 28
  localparam logic [6:0] SEL_SYNC       = 7'h1d; // 29
  localparam logic [6:0] SEL_WEAR       = 7'h1e; // 30
  localparam logic [6:0] SEL_PID        = 7'h2b; // 43
  localparam logic [6:0] SEL_FWD        = 7'h34; // 52
  localparam logic [6:0] SEL_REV        = 7'h35; // 53
  localparam logic [6:0] SEL_REMOTE     = 7'h36; // 54
  localparam logic [6:0] SEL_WIRE       = 7'h3b; // 59
  localparam logic [6:0] SEL_SPEED      = 7'h46; // 70
  localparam logic [6:0] SEL_ALARM      = 7'h63; // 99
  localparam logic [6:0] SEL_SAFETY     = 7'h65; // 101
  // contactor sequencer states
  typedef enum logic [1:0] {CtOff, CtOn, CtStopping} dso_ct_e;
endpackage : dso_pkg

// [hdl/dso_ms_timer.sv]
// dso_ms_timer: counts whole milliseconds on a shared tick
// assumes the tick is one cycle wide and reset is synchronous
`timescale 1ns/1ps
`default_nettype none
module dso_ms_timer #(
  parameter int unsigned LIMIT_MS = 100      // count at which done rises
) (
  input  wire logic sys_clk,                 // control clock
  input  wire logic rst,                     // sync reset, high
  input  wire logic clear,                   // restart from zero
  input  wire logic msTick,                  // one-cycle millisecond tick
  output logic      done                     // limit reached, level
);
  // limits are held to 1 through 1000, inside the ten-bit counter's range
  if (LIMIT_MS < 1 || LIMIT_MS > 1000) begin : g_badLimit
    $error("dso_ms_timer: bad limit");
  end

  typedef struct packed {
    logic [9:0] count;                       // elapsed milliseconds
    logic       done;                        // limit reached
  } dso_tmr_s;

  dso_tmr_s q, d;

  // saturate at the limit so done holds until cleared
  always_comb begin
    d = q;
    if (clear) begin
      d.count = 10'h000;
      d.done  = 1'b0;
    end else if (msTick && !q.done) begin
      d.count = q.count + 10'h001;
      d.done  = (d.count >= 10'(LIMIT_MS));
    end
  end

  // state register, cleared by reset
  always_ff @(posedge sys_clk) begin
    if (rst) q <= '0;
    else     q <= d;
  end

  assign done = q.done;
endmodule // dso_ms_timer
`default_nettype wire

// [hdl/dso_out_select.sv]
// dso_out_select: routes one flag by assignment code, then polarity
// assumes flags arrive indexed by their 7-bit selector code
`timescale 1ns/1ps
`default_nettype none
module dso_out_select (
  input  wire logic [127:0] flags,           // flags indexed by code
  input  wire logic [10:0]  code,            // terminal assignment code
  output logic              pinLevel         // routed level, combinational
);
  logic [10:0] baseCode;                     // code with inversion removed
  logic        invert;                       // negative logic chosen

  // codes of 1000 and above select the same flag inverted
  always_comb begin
    invert   = (code >= dso_pkg::NEG_OFFSET);
    baseCode = invert ? code - dso_pkg::NEG_OFFSET : code;
    // out-of-range codes route to a low level before polarity
    if (baseCode > 11'h07f) pinLevel = invert;
    else pinLevel = flags[baseCode[6:0]] ^ invert;
  end
endmodule // dso_out_select
`default_nettype wire

// [hdl/dso_status_out.sv]
// dso_status_out: drive status flags routed to digital output terminals
// assumes all inputs are synchronous to sys_clk and already decoded
// by the drive's control core; temperatures in degrees C, current in uA
//
// Overview of operation
// - torque flag high when braking, low driving
// - limiting flag, held at least 100 ms
// - delayed limiting flag after 20 ms continuous
// - four actions count as output limiting
// - keypad flag follows keypad run source
// - ready needs preparation done and no protection
// - contactor on at run, off after stop
// - contactor drops at once on coast/alarm
// - comm output follows only link-written value
// - heat warning above trip-5, release at trip-8
// - locked circulation fan also raises heat warning
// - sync flag while inside completion angle
// - wear flag on expired life or fan lock
// - closed loop flag: pid enabled and running
// - forward/reverse flags, both low when stopped
// - remote flag follows remote mode
// - wire break below 2 mA input
// - speed valid on, off after 100 ms low
// - speed criterion chosen by select under sensored
// - alarm flag while in alarm mode
// - safety fault flag on enable circuit failure
// - code plus 1000 inverts output polarity
`timescale 1ns/1ps
`default_nettype none
module dso_status_out #(
  parameter int unsigned NUM_OUT   = 6,      // digital output terminals
  parameter int unsigned TEMP_W    = 8,      // temperature width
  parameter int unsigned SPEED_W   = 16      // speed word width
) (
  input  wire logic sys_clk,                          // control clock
  input  wire logic rst,                              // sync reset, high
  input  wire logic torqueBraking,                    // torque sign: brake
  input  wire logic torqueLimiting,                   // torque limit on
  input  wire logic swCurrentLimiting,                // sw current limit on
  input  wire logic hwOvercurrentLimiting,            // hw ocl active
  input  wire logic hw_overcurrent_limit_enable,      // hw ocl enabled
  input  wire logic antiRegenDecel,                   // auto decel active
  input  wire logic keypadSelected,                   // keypad run source
  input  wire logic prepDone,                         // precharge+init done
  input  wire logic protectionActive,                 // protection tripped
  input  wire logic runCommand,                       // run command on
  input  wire logic coastCommand,                     // coast-to-stop
  input  wire logic motorStopped,                     // decel finished
  input  wire logic commValue,                        // link-written bit
  input  wire logic [TEMP_W-1:0] heatsinkTemp,        // heat-sink temp
  input  wire logic [TEMP_W-1:0] heatsink_trip,       // trip temperature
  input  wire logic fanLocked,                        // circ fan locked
  input  wire logic syncRunning,                      // synchronous running
  input  wire logic insideSyncAngle,                  // inside angle
  input  wire logic lifeExpired,                      // caps/fan life over
  input  wire logic pid_cancel_input,                 // high cancels pid
  input  wire logic runningFwd,                       // turning forward
  input  wire logic runningRev,                       // turning reverse
  input  wire logic remoteMode,                       // remote selected
  input  wire logic [15:0] currentInputUa,            // current input uA
  input  wire logic sensoredVector,                   // sensored control
  input  wire logic speed_criterion_select,           // 1 = detected speed if sensored
  input  wire logic [SPEED_W-1:0] refSpeed,           // reference speed
  input  wire logic [SPEED_W-1:0] detSpeed,           // detected speed
  input  wire logic [SPEED_W-1:0] stop_frequency_setting, // stop level
  input  wire logic alarmMode,                        // alarm mode entered
  input  wire logic enableCircuitFail,                // enable ckt failure
  input  wire logic [NUM_OUT*11-1:0] assignCodes,     // 11-bit code each
  output logic [NUM_OUT-1:0] outPins                  // terminal levels
);
  // refuse sizes the selectors and margins cannot serve
  if (NUM_OUT < 1 || NUM_OUT > 16) begin : g_badNum
    $error("dso_status_out: NUM_OUT");
  end
  if (TEMP_W < 5 || SPEED_W < 2) begin : g_badWidth
    $error("dso_status_out: widths");
  end

  typedef dso_pkg::dso_ct_e dso_ct_e_t;

  // every state bit of the block except the timers' own, registered in one place
  typedef struct packed {
    logic [15:0]        tickCnt;     // millisecond prescaler
    logic               msTick;      // one-cycle tick
    dso_ct_e_t          ct;          // contactor sequencer
    logic               heatHot;     // temperature hysteresis state
    logic               speedOn;     // speed valid flag
    logic               limHeld;     // limiting minimum width pending
    logic [NUM_OUT-1:0] pins;        // registered terminal levels
  } dso_state_s;

  // adds the margin to the temperature so a low trip level cannot wrap
  function automatic logic hotter(input logic [TEMP_W-1:0] temp,
                                  input logic [TEMP_W-1:0] trip,
                                  input logic [TEMP_W-1:0] margin);
    return ({1'b0, temp} + {1'b0, margin}) > {1'b0, trip};
  endfunction

  dso_state_s q, d;

  logic limitAny;                    // any limiting action
  logic limHoldDone;                 // 100 ms minimum width elapsed
  logic limDlyDone;                  // 20 ms persistence elapsed
  logic speedLowDone;                // 100 ms at or below stop level
  logic speedAbove;                  // chosen speed above stop level
  logic [SPEED_W-1:0] judgedSpeed;   // speed under judgement
  logic [127:0] flags;               // flags indexed by code
  logic [NUM_OUT-1:0] routed;        // selector outputs

  // four limiting sources; hw limiting counts only when enabled
  assign limitAny = torqueLimiting | swCurrentLimiting
                  | (hwOvercurrentLimiting & hw_overcurrent_limit_enable)
                  | antiRegenDecel;

  // minimum-width timer restarts on every limiting cycle
  dso_ms_timer #(.LIMIT_MS(dso_pkg::LIMIT_MIN_MS)) u_limHold (
    .sys_clk (sys_clk),
    .rst     (rst),
    .clear   (limitAny),
    .msTick  (q.msTick),
    .done    (limHoldDone)
  );

  // persistence timer cleared whenever limiting drops
  dso_ms_timer #(.LIMIT_MS(dso_pkg::LIMIT_DLY_MS)) u_limDly (
    .sys_clk (sys_clk),
    .rst     (rst),
    .clear   (!limitAny),
    .msTick  (q.msTick),
    .done    (limDlyDone)
  );

  // off-delay timer restarts while the speed stays above
  dso_ms_timer #(.LIMIT_MS(dso_pkg::SPEED_HOLD_MS)) u_speedLow (
    .sys_clk (sys_clk),
    .rst     (rst),
    .clear   (speedAbove),
    .msTick  (q.msTick),
    .done    (speedLowDone)
  );

  // sensorless vector always judges on the reference speed
  always_comb begin
    judgedSpeed = (sensoredVector && speed_criterion_select)
                ? detSpeed : refSpeed;
    speedAbove  = judgedSpeed > stop_frequency_setting;
  end

  // flag vector: index is the assignment code of each flag
  always_comb begin
    flags = '0;
    flags[dso_pkg::SEL_TORQUE]    = torqueBraking;
    // limiting flag stays up until the hold timer runs out
    flags[dso_pkg::SEL_LIM]       = limitAny | q.limHeld;
    flags[dso_pkg::SEL_LIMDLY]    = limDlyDone;
    flags[dso_pkg::SEL_KEYPAD]    = keypadSelected;
    flags[dso_pkg::SEL_READY]     = prepDone & !protectionActive;
    flags[dso_pkg::SEL_CONTACTOR] = (q.ct != dso_pkg::CtOff);
    flags[dso_pkg::SEL_COMM]      = commValue;
    flags[dso_pkg::SEL_HEAT]      = q.heatHot | fanLocked;
    flags[dso_pkg::SEL_SYNC]      = syncRunning & insideSyncAngle;
    flags[dso_pkg::SEL_WEAR]      = lifeExpired | fanLocked;
    // stays on through a low-flow pause as long as run is held
    flags[dso_pkg::SEL_PID]       = !pid_cancel_input & runCommand;
    flags[dso_pkg::SEL_FWD]       = runningFwd & !runningRev;
    flags[dso_pkg::SEL_REV]       = runningRev & !runningFwd;
    flags[dso_pkg::SEL_REMOTE]    = remoteMode;
    flags[dso_pkg::SEL_WIRE]      =
      currentInputUa < 16'(dso_pkg::WIRE_BREAK_UA);
    flags[dso_pkg::SEL_SPEED]     = q.speedOn;
    flags[dso_pkg::SEL_ALARM]     = alarmMode;
    flags[dso_pkg::SEL_SAFETY]    = enableCircuitFail;
  end

  // one selector per terminal, polarity applied after selection
  for (genvar i = 0; i < NUM_OUT; i++) begin : g_sel
    dso_out_select u_sel (
      .flags    (flags),
      .code     (assignCodes[i*11 +: 11]),
      .pinLevel (routed[i])
    );
  end

  // next-state logic for every registered field
  always_comb begin
    d = q;
    // single millisecond tick shared by all timers
    if (q.tickCnt == 16'(dso_pkg::TICK_CYCLES - 1)) begin
      d.tickCnt = 16'h0000;
      d.msTick  = 1'b1;
    end else begin
      d.tickCnt = q.tickCnt + 16'h0001;
      d.msTick  = 1'b0;
    end

    // contactor sequencer
    case (q.ct)
      dso_pkg::CtOff: begin
        if (runCommand && !coastCommand && !alarmMode)
          d.ct = dso_pkg::CtOn;
      end
      dso_pkg::CtOn: begin
        if (!runCommand) d.ct = dso_pkg::CtStopping;
      end
      dso_pkg::CtStopping: begin
        // a fresh run during decel keeps the contactor closed
        if (runCommand) d.ct = dso_pkg::CtOn;
        else if (motorStopped) d.ct = dso_pkg::CtOff;
      end
      default: d.ct = dso_pkg::CtOff;
    endcase
    // coast or alarm override everything, no deceleration wait
    if (coastCommand || alarmMode) d.ct = dso_pkg::CtOff;

    // hysteresis band: on above trip-5, off at or below trip-8
    if (hotter(heatsinkTemp, heatsink_trip, TEMP_W'(dso_pkg::HS_ON_MARGIN)))
      d.heatHot = 1'b1;
    else if (!hotter(heatsinkTemp, heatsink_trip,
                     TEMP_W'(dso_pkg::HS_OFF_MARGIN)))
      d.heatHot = 1'b0;

    // speed valid: rise at once, fall after the low hold
    if (speedAbove) d.speedOn = 1'b1;
    else if (speedLowDone) d.speedOn = 1'b0;

    // limiting hold: set by any limiting cycle, dropped once the timer
    // has run its minimum width; reset leaves it low, not pending
    if (limitAny) d.limHeld = 1'b1;
    else if (limHoldDone) d.limHeld = 1'b0;

    d.pins = routed;
  end

  // one register stage; outputs come straight from it
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      q.tickCnt <= 16'h0000;
      q.msTick  <= 1'b0;
      q.ct      <= dso_pkg::CtOff;
      q.heatHot <= 1'b0;
      q.speedOn <= 1'b0;
      q.limHeld <= 1'b0;
      q.pins    <= '0;
    end else begin
      q <= d;
    end
  end

  assign outPins = q.pins;
endmodule // dso_status_out
`default_nettype wire

// [verification/dso_status_out_sva.sv]
// checker for the status output block, watching terminal 0
// assumes the bench changes codes only through ordinary clocked drives
`timescale 1ns/1ps
`default_nettype none
module dso_status_out_sva #(
  parameter int unsigned NUM_OUT = 6,          // terminals
  parameter int unsigned TEMP_W  = 8           // temperature width
) (
  input wire logic                 sys_clk,        // clock
  input wire logic                 rst,            // sync reset
  input wire logic                 torqueBraking,  // torque sign
  input wire logic                 keypadSelected, // keypad source
  input wire logic                 coastCommand,   // coast stop
  input wire logic                 alarmMode,      // alarm mode
  input wire logic [TEMP_W-1:0]    heatsinkTemp,   // heat-sink temp
  input wire logic [TEMP_W-1:0]    heatsink_trip,  // trip temp
  input wire logic                 fanLocked,      // fan locked
  input wire logic                 runningFwd,     // forward
  input wire logic                 runningRev,     // reverse
  input wire logic [15:0]          currentInputUa, // input current
  input wire logic [NUM_OUT*11-1:0] assignCodes,   // codes
  input wire logic [NUM_OUT-1:0]   outPins         // terminal levels
);
  logic [10:0]     c;    // terminal 0 code
  logic [TEMP_W:0] tmp;  // widened so temp plus margin cannot wrap
  logic [TEMP_W:0] trp;  // widened trip level
  assign c   = assignCodes[10:0];
  assign tmp = {1'b0, heatsinkTemp};
  assign trp = {1'b0, heatsink_trip};
  // one clock domain, so clock and reset are given once
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  a_torque_polarity: assert property (
    $past(c) == dso_pkg::SEL_TORQUE && !$past(rst) |-> outPins[0] ==
    $past(torqueBraking)) else $error("torque flag wrong");
  a_keypad_source: assert property (
    $past(c) == dso_pkg::SEL_KEYPAD && !$past(rst) |-> outPins[0] ==
    $past(keypadSelected)) else $error("keypad flag wrong");
  a_run_direction: assert property (
    $past(c) == dso_pkg::SEL_FWD && !$past(rst) |-> outPins[0] ==
    $past(runningFwd && !runningRev)) else $error("forward flag wrong");
  a_wire_break: assert property (
    $past(c) == dso_pkg::SEL_WIRE && !$past(rst) |-> outPins[0] ==
    $past(currentInputUa < 16'h07d0)) else $error("wire break wrong");
  a_inverted_alarm: assert property (
    $past(c) == dso_pkg::NEG_OFFSET + dso_pkg::SEL_ALARM && !$past(rst)
    |-> outPins[0] == !$past(alarmMode)) else $error("inverted pin wrong");
  a_contactor_drop: assert property (
    c == dso_pkg::SEL_CONTACTOR && (coastCommand || alarmMode) ##1
    c == dso_pkg::SEL_CONTACTOR |=> !outPins[0]) else $error("no drop");
  a_heat_warn_on: assert property (
    c == dso_pkg::SEL_HEAT && tmp + dso_pkg::HS_ON_MARGIN > trp ##1
    c == dso_pkg::SEL_HEAT |=> outPins[0]) else $error("no heat warning");
  a_heat_release: assert property (
    c == dso_pkg::SEL_HEAT && tmp + dso_pkg::HS_OFF_MARGIN <= trp &&
    !fanLocked ##1 c == dso_pkg::SEL_HEAT && !fanLocked |=> !outPins[0])
    else $error("heat warning stuck");
endmodule // dso_status_out_sva
bind dso_status_out dso_status_out_sva #(.NUM_OUT(NUM_OUT),
  .TEMP_W(TEMP_W)) chk (.sys_clk, .rst, .torqueBraking, .keypadSelected,
  .coastCommand, .alarmMode, .heatsinkTemp, .heatsink_trip, .fanLocked,
  .runningFwd, .runningRev, .currentInputUa, .assignCodes, .outPins);
`default_nettype wire

// [verification/dso_contactor_model.sv]
// contactor on a status output terminal: contacts follow the coil
// assumes the coil terminal is a clean level on sys_clk
`timescale 1ns/1ps
`default_nettype none
module dso_contactor_model (
  input  wire logic sys_clk, // clock
  input  wire logic coil,    // coil level from the terminal
  output var  logic closed   // main contacts
);
  // contacts pull in one cycle late, so the bench sees real lag
  always_ff @(posedge sys_clk) begin
    closed <= coil;
  end
endmodule // dso_contactor_model
`default_nettype wire

// [verification/tb.sv]
// self-checking bench for the drive status output block
// assumes long ms timers are out of reach; only short effects are checked
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic sys_clk, rst, torqueBraking, torqueLimiting, swCurrentLimiting;
  logic hwOvercurrentLimiting, hw_overcurrent_limit_enable, antiRegenDecel;
  logic keypadSelected, prepDone, protectionActive, runCommand, fanLocked;
  logic coastCommand, motorStopped, commValue, syncRunning, lifeExpired;
  logic insideSyncAngle, pid_cancel_input, runningFwd, runningRev;
  logic remoteMode, sensoredVector, speed_criterion_select, alarmMode;
  logic enableCircuitFail, relayClosed;                  // relay contacts
  logic [7:0]  heatsinkTemp, heatsink_trip;              // degrees C
  logic [15:0] currentInputUa, refSpeed, detSpeed, stop_frequency_setting;
  logic [65:0] assignCodes;                              // six codes
  logic [5:0]  outPins;                                  // terminals
  int          nMismatch = 0;                            // failures
  int          checksDone = 0;                           // comparisons
  dso_status_out uut (.sys_clk, .rst, .torqueBraking, .torqueLimiting,
    .swCurrentLimiting, .hwOvercurrentLimiting, .hw_overcurrent_limit_enable,
    .antiRegenDecel, .keypadSelected, .prepDone, .protectionActive,
    .runCommand, .coastCommand, .motorStopped, .commValue, .heatsinkTemp,
    .heatsink_trip, .fanLocked, .syncRunning, .insideSyncAngle, .lifeExpired,
    .pid_cancel_input, .runningFwd, .runningRev, .remoteMode, .currentInputUa,
    .sensoredVector, .speed_criterion_select, .refSpeed, .detSpeed,
    .stop_frequency_setting, .alarmMode, .enableCircuitFail, .assignCodes,
    .outPins);
  dso_contactor_model relay (.sys_clk, .coil(outPins[1]),
    .closed(relayClosed));
  // 50 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  task automatic finish_test;
    if (nMismatch == 0 && checksDone > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checksDone++;
    if (seen !== exp) begin
      nMismatch++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // every untimed flag settles within two edges; three leaves a margin
  task automatic see(input logic e);
    wt(3);
    chk({7'h00, outPins[0]}, {7'h00, e});
  endtask
  task automatic code(input int t, input logic [6:0] s, input logic inv);
    assignCodes[t*11 +: 11] <= {4'h0, s} + (inv ? dso_pkg::NEG_OFFSET : '0);
  endtask
  // raise or drop the cause behind a plain flag, both sync inputs together
  task automatic cause(input logic [6:0] s, input logic v);
    case (s)
      dso_pkg::SEL_TORQUE: torqueBraking <= v;
      dso_pkg::SEL_KEYPAD: keypadSelected <= v;
      dso_pkg::SEL_READY:  prepDone <= v;
      dso_pkg::SEL_COMM:   commValue <= v;
      dso_pkg::SEL_SYNC:   {syncRunning, insideSyncAngle} <= {v, v};
      dso_pkg::SEL_WEAR:   lifeExpired <= v;
      dso_pkg::SEL_PID:    runCommand <= v;
      dso_pkg::SEL_FWD:    runningFwd <= v;
      dso_pkg::SEL_REV:    runningRev <= v;
      dso_pkg::SEL_REMOTE: remoteMode <= v;
      dso_pkg::SEL_WIRE:   currentInputUa <= v ? 16'h07cf : 16'h07d0;
      dso_pkg::SEL_ALARM:  alarmMode <= v;
      default:             enableCircuitFail <= v;
    endcase
  endtask
  // each plain flag, normal then inverted, idle then raised
  task automatic t_flags;
    logic [6:0] sel [13];
    sel = '{dso_pkg::SEL_TORQUE, dso_pkg::SEL_KEYPAD, dso_pkg::SEL_READY,
      dso_pkg::SEL_COMM, dso_pkg::SEL_SYNC, dso_pkg::SEL_WEAR,
      dso_pkg::SEL_PID, dso_pkg::SEL_FWD, dso_pkg::SEL_REV,
      dso_pkg::SEL_REMOTE, dso_pkg::SEL_WIRE, dso_pkg::SEL_ALARM,
      dso_pkg::SEL_SAFETY};
    for (int p = 0; p < 2; p++) begin
      foreach (sel[i]) begin
        code(0, sel[i], p[0]);
        see(p[0]);
        cause(sel[i], 1'b1);
        see(!p[0]);
        cause(sel[i], 1'b0);
      end
    end
  endtask
  // flags whose cause is only half present stay low; enabled hw limiting raises and holds
  task automatic t_gates;
    code(0, dso_pkg::SEL_READY, 1'b0);
    {prepDone, protectionActive} <= 2'b11;
    see(1'b0);
    code(0, dso_pkg::SEL_PID, 1'b0);
    {prepDone, protectionActive, runCommand, pid_cancel_input} <= 4'h3;
    see(1'b0);
    code(0, dso_pkg::SEL_FWD, 1'b0);
    {runCommand, pid_cancel_input, runningFwd, runningRev} <= 4'h3;
    see(1'b0);
    code(0, dso_pkg::SEL_SYNC, 1'b0);
    {runningFwd, runningRev, insideSyncAngle} <= 3'h1;
    see(1'b0);
    code(0, dso_pkg::SEL_LIM, 1'b0);
    hwOvercurrentLimiting <= 1'b1;
    see(1'b0);
    hw_overcurrent_limit_enable <= 1'b1;
    see(1'b1);
    {hwOvercurrentLimiting, hw_overcurrent_limit_enable} <= 2'b00;
    see(1'b1);
    code(0, dso_pkg::SEL_LIMDLY, 1'b0);
    {insideSyncAngle, torqueLimiting, hwOvercurrentLimiting} <= 3'h3;
    {swCurrentLimiting, antiRegenDecel} <= 2'h3;
    see(1'b0);
    {torqueLimiting, swCurrentLimiting, antiRegenDecel} <= 3'h0;
    hwOvercurrentLimiting <= 1'b0;
    code(0, 7'h00, 1'b1);
    see(1'b1);
  endtask
  task automatic t_contactor;
    code(0, dso_pkg::SEL_CONTACTOR, 1'b0);
    code(1, dso_pkg::SEL_CONTACTOR, 1'b0);
    motorStopped <= 1'b1;
    see(1'b0);
    {motorStopped, runCommand} <= 2'b01;
    see(1'b1);
    wt(1);
    chk({7'h00, relayClosed}, 8'h01);
    runCommand <= 1'b0;
    see(1'b1);
    motorStopped <= 1'b1;
    see(1'b0);
    {motorStopped, runCommand} <= 2'b01;
    see(1'b1);
    coastCommand <= 1'b1;
    see(1'b0);
    coastCommand <= 1'b0;
    see(1'b1);
    alarmMode <= 1'b1;
    see(1'b0);
    {alarmMode, runCommand} <= 2'b00;
  endtask
  // hysteresis worked out here from the two margins
  task automatic t_heat;
    logic [7:0] tmp [4] = '{8'h5f, 8'h60, 8'h5d, 8'h5c};
    logic       h = 1'b0;
    code(0, dso_pkg::SEL_HEAT, 1'b0);
    foreach (tmp[i]) begin
      heatsinkTemp <= tmp[i];
      h = (tmp[i] + dso_pkg::HS_ON_MARGIN > heatsink_trip) ||
        (h && tmp[i] + dso_pkg::HS_OFF_MARGIN > heatsink_trip);
      see(h);
    end
    fanLocked <= 1'b1;
    see(1'b1);
    code(0, dso_pkg::SEL_WEAR, 1'b0);
    see(1'b1);
    fanLocked <= 1'b0;
    see(1'b0);
  endtask
  // speed flag on both criteria, with a reset in mid-run to drop it
  task automatic t_speed;
    code(0, dso_pkg::SEL_SPEED, 1'b0);
    {sensoredVector, speed_criterion_select} <= 2'b11;
    refSpeed <= stop_frequency_setting + 16'h0100;
    detSpeed <= stop_frequency_setting;
    see(1'b0);
    detSpeed <= stop_frequency_setting + 16'h0001;
    see(1'b1);
    detSpeed <= 16'h0000;
    see(1'b1);
    rst <= 1'b1;
    wt(2);
    chk({2'h0, outPins}, 8'h00);
    rst <= 1'b0;
    see(1'b0);
    sensoredVector <= 1'b0;
    see(1'b1);
  endtask
  // cut a hang short; the whole run needs well under a thousand cycles
  initial begin
    wt(20000);
    nMismatch++;
    finish_test;
  end
  initial begin
    {torqueBraking, torqueLimiting, swCurrentLimiting, hwOvercurrentLimiting,
      hw_overcurrent_limit_enable, antiRegenDecel, keypadSelected, prepDone,
      protectionActive, runCommand, coastCommand, motorStopped, commValue,
      fanLocked, syncRunning, insideSyncAngle, lifeExpired, pid_cancel_input,
      runningFwd, runningRev, remoteMode, sensoredVector, alarmMode,
      speed_criterion_select, enableCircuitFail} = '0;
    {heatsinkTemp, heatsink_trip} = {8'h14, 8'h64};
    {currentInputUa, refSpeed, detSpeed} = {16'h07d0, 16'h0000, 16'h0000};
    stop_frequency_setting = 16'h0100;
    assignCodes = {6{11'h44b}};
    rst = 1'b1;
    wt(16);
    chk({2'h0, outPins}, 8'h00);
    rst <= 1'b0;
    wt(3);
    chk({2'h0, outPins}, 8'h3f);
    t_flags();
    t_gates();
    t_contactor();
    t_heat();
    t_speed();
    finish_test;
  end
endmodule // tb
`default_nettype wire
